// ---- htfs_pkg.sv ----
// Purpose: Shared constants and carrier types for the haptic trim/fault/snippet register slice
// Assumes: Byte-wide registers, one per 32-bit Wishbone word, byte address = index * 4
// Notes:   Printed offsets are register indices; not all are multiples of four
package htfs_pkg;

	// Register indices as printed
	localparam logic [7:0] HTFS_IDX_SLEW      = 8'h62;
	localparam logic [7:0] HTFS_IDX_MISC      = 8'h6e;
	localparam logic [7:0] HTFS_IDX_EVENT     = 8'h81;
	localparam logic [7:0] HTFS_IDX_STATE     = 8'h82;
	localparam logic [7:0] HTFS_IDX_MASK      = 8'h83;
	localparam logic [7:0] HTFS_IDX_SNP_FIRST = 8'h84;
	localparam logic [7:0] HTFS_IDX_SNP_LAST  = 8'he7;
	localparam int         HTFS_SNP_DEPTH     = 100;
	localparam int         HTFS_ADR_W         = 10;

	// Field positions
	localparam int HTFS_POS_HS_SLEW   = 0;
	localparam int HTFS_POS_LS_SLEW   = 2;
	localparam int HTFS_POS_OFFSET_EN = 0;
	localparam int HTFS_POS_FRQ_HOLD  = 1;
	localparam int HTFS_POS_DLY_BYP   = 2;
	localparam int HTFS_POS_SAT_EVENT = 2;
	localparam int HTFS_POS_SAT_STATE = 7;
	localparam int HTFS_POS_SAT_MASK  = 7;

	// Reset values
	localparam logic [1:0] HTFS_RST_SLEW      = 2'h3;
	localparam logic       HTFS_RST_DLY_BYP   = 1'h0;
	localparam logic       HTFS_RST_FRQ_HOLD  = 1'h0;
	localparam logic       HTFS_RST_OFFSET_EN = 1'h1;
	localparam logic       HTFS_RST_SAT_MASK  = 1'h0;
	localparam logic [7:0] HTFS_RST_SNP       = 8'h00;

	// Configuration handed to the analog and tracking logic
	typedef struct packed {
		logic [1:0] low_side_slew_select;
		logic [1:0] high_side_slew_select;
		logic       delay_bypass;
		logic       freq_hold_on_reversal;
		logic       conversion_offset_enable;
	} htfs_cfg_t;

	// Wishbone request from the master
	typedef struct packed {
		logic                  cyc;
		logic                  stb;
		logic                  we;
		logic [3:0]            sel;
		logic [HTFS_ADR_W-1:0] adr;
		logic [31:0]           dat;
	} htfs_wb_req_t;

endpackage

// ---- htfs_snippet_mem.sv ----
// Purpose: 100-byte waveform snippet store in flip-flops
// Assumes: One write port, one read port addressed by index
// Notes:   Read data is combinational; the bus slave registers it
`timescale 1ns/1ps
module htfs_snippet_mem (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       we_i,
	input  wire logic [6:0] idx_i,
	input  wire logic [7:0] wdat_i,
	input  wire logic [6:0] ridx_i,
	output logic      [7:0] rdat_o
);
	import htfs_pkg::*;

	logic [7:0] mem_q [HTFS_SNP_DEPTH];

	// Each byte resets to zero and takes writes at its own index
	for (genvar g = 0; g < HTFS_SNP_DEPTH; g++) begin : g_byte
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mem_q[g] <= HTFS_RST_SNP;
			end else if (we_i && idx_i == 7'(g)) begin
				mem_q[g] <= wdat_i;
			end
		end
	end

	// Out-of-range index reads zero; the decoder asks for one only on non-snippet words, where the data is unused
	assign rdat_o = (ridx_i < 7'(HTFS_SNP_DEPTH)) ? mem_q[ridx_i] : 8'h00;
endmodule

// ---- htfs_irq.sv ----
// Purpose: Sticky converter saturation event with mask and level interrupt
// Assumes: clr_i is a write-one-to-clear pulse from the bus
// Notes:   A new event in the clearing cycle keeps the flag set
`timescale 1ns/1ps
module htfs_irq (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic event_i,
	input  wire logic clr_i,
	input  wire logic mask_i,
	output logic      flag_o,
	output logic      irq_o
);
	logic flag_q;
	logic flag_d;

	// Set wins over clear so no event is lost
	always_comb begin
		flag_d = flag_q;
		if (clr_i) begin
			flag_d = 1'b0;
		end
		if (event_i) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;
	assign irq_o  = flag_q & ~mask_i;
endmodule

// ---- htfs_regs.sv ----
// Purpose: Register slice of a haptic driver: bridge slew trim, misc config, saturation fault, snippet memory
// Assumes: Classic Wishbone slave, 32-bit data, byte registers in lane 0, byte address = index * 4
// Notes:   Ack, or err on unmapped words, comes one cycle after the request is seen and drops the next cycle
// Operation
// - Low-side slew field, four steps, resets three
// - High-side slew field, four steps, resets three
// - Delay comparator bypass bit, resets zero
// - Hold frequency updates on polarity reversal
// - Conversion offset enable, resets one
// - Sticky saturation event set by converter
// - Writing one to event bit clears it
// - Read-only saturation state bit, resets zero
// - Saturation interrupt mask bit, resets zero
// - Hundred snippet bytes at consecutive indices
// - Snippet bytes eight-bit read-write, reset zero
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module htfs_regs (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [htfs_pkg::HTFS_ADR_W-1:0] wb_adr_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	output logic                               wb_err_o,
	input  wire logic                          adc_saturated_i,
	input  wire logic                          polarity_reversed_i,
	input  wire logic                          freq_update_req_i,
	output logic                               freq_update_en_o,
	output htfs_pkg::htfs_cfg_t                cfg_o,
	output logic                               irq_o
);
	import htfs_pkg::*;

	// Bus phases, gray along idle -> answer
	typedef enum logic [1:0] {
		HTFS_IDLE = 2'b00,
		HTFS_ANS  = 2'b01
	} htfs_state_t;

	typedef struct packed {
		htfs_state_t st;
		logic        ack;
		logic        err;
		logic [31:0] rdat;
		htfs_cfg_t   cfg;
		logic        mask;
		logic        upd_en;
	} htfs_regs_t;

	htfs_regs_t   s_q;
	htfs_regs_t   s_d;
	htfs_wb_req_t req;
	logic [7:0]   idx;
	logic         hit_snp;
	logic         hit_reg;
	logic         take;
	logic         wr;
	logic [6:0]   snp_idx;
	logic [7:0]   snp_rdat;
	logic         sat_flag;
	logic         sat_clr;
	logic         irq_int;
	logic [7:0]   rd_byte;

	// Carry bus inputs as one request
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

	// Decode: word index from the byte address, low two bits ignored
	assign idx     = req.adr[9:2];
	assign hit_snp = (idx >= HTFS_IDX_SNP_FIRST) && (idx <= HTFS_IDX_SNP_LAST);
	assign snp_idx = 7'(idx - HTFS_IDX_SNP_FIRST);
	assign hit_reg = hit_snp || idx == HTFS_IDX_SLEW || idx == HTFS_IDX_MISC ||
		idx == HTFS_IDX_EVENT || idx == HTFS_IDX_STATE || idx == HTFS_IDX_MASK;
	// A request is taken once, in idle; the answer cycle blocks a second take
	assign take    = req.cyc && req.stb && s_q.st == HTFS_IDLE;
	// Only lane 0 carries a register; writes without it store nothing
	assign wr      = take && req.we && req.sel[0] && hit_reg;
	assign sat_clr = wr && idx == HTFS_IDX_EVENT && req.dat[HTFS_POS_SAT_EVENT];

	htfs_snippet_mem u_snp (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.we_i   (wr && hit_snp),
		.idx_i  (snp_idx),
		.wdat_i (req.dat[7:0]),
		.ridx_i (snp_idx),
		.rdat_o (snp_rdat)
	);

	htfs_irq u_irq (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.event_i (adc_saturated_i),
		.clr_i   (sat_clr),
		.mask_i  (s_q.mask),
		.flag_o  (sat_flag),
		.irq_o   (irq_int)
	);

	// Read multiplexer; reserved bits read as zero
	always_comb begin
		rd_byte = 8'h00;
		if (hit_snp) begin
			rd_byte = snp_rdat;
		end else begin
			case (idx)
				HTFS_IDX_SLEW: begin
					rd_byte[HTFS_POS_LS_SLEW +: 2] = s_q.cfg.low_side_slew_select;
					rd_byte[HTFS_POS_HS_SLEW +: 2] = s_q.cfg.high_side_slew_select;
				end
				HTFS_IDX_MISC: begin
					rd_byte[HTFS_POS_DLY_BYP]   = s_q.cfg.delay_bypass;
					rd_byte[HTFS_POS_FRQ_HOLD]  = s_q.cfg.freq_hold_on_reversal;
					rd_byte[HTFS_POS_OFFSET_EN] = s_q.cfg.conversion_offset_enable;
				end
				HTFS_IDX_EVENT: begin
					rd_byte[HTFS_POS_SAT_EVENT] = sat_flag;
				end
				HTFS_IDX_STATE: begin
					rd_byte[HTFS_POS_SAT_STATE] = sat_flag;
				end
				HTFS_IDX_MASK: begin
					rd_byte[HTFS_POS_SAT_MASK] = s_q.mask;
				end
				default: begin
					rd_byte = 8'h00;
				end
			endcase
		end
	end

	// Next state of the slice, apart from the snippet bytes and the saturation flag
	always_comb begin
		s_d     = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		case (s_q.st)
			HTFS_IDLE: begin
				if (take) begin
					s_d.st   = HTFS_ANS;
					s_d.ack  = hit_reg;
					s_d.err  = !hit_reg; // Unmapped words answer with err, never hang the bus
					s_d.rdat = {24'h000000, rd_byte};
				end
			end
			HTFS_ANS: begin
				s_d.st = HTFS_IDLE;
			end
			default: begin
				s_d.st = HTFS_IDLE;
			end
		endcase
		if (wr && idx == HTFS_IDX_SLEW) begin
			s_d.cfg.low_side_slew_select  = req.dat[HTFS_POS_LS_SLEW +: 2];
			s_d.cfg.high_side_slew_select = req.dat[HTFS_POS_HS_SLEW +: 2];
		end
		if (wr && idx == HTFS_IDX_MISC) begin
			s_d.cfg.delay_bypass             = req.dat[HTFS_POS_DLY_BYP];
			s_d.cfg.freq_hold_on_reversal    = req.dat[HTFS_POS_FRQ_HOLD];
			s_d.cfg.conversion_offset_enable = req.dat[HTFS_POS_OFFSET_EN];
		end
		if (wr && idx == HTFS_IDX_MASK) begin
			s_d.mask = req.dat[HTFS_POS_SAT_MASK];
		end
		// Update gate registered so the tracker sees a clean level
		s_d.upd_en = freq_update_req_i && !(s_q.cfg.freq_hold_on_reversal && polarity_reversed_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q                              <= '0;
			s_q.st                           <= HTFS_IDLE;
			s_q.cfg.low_side_slew_select     <= HTFS_RST_SLEW;
			s_q.cfg.high_side_slew_select    <= HTFS_RST_SLEW;
			s_q.cfg.delay_bypass             <= HTFS_RST_DLY_BYP;
			s_q.cfg.freq_hold_on_reversal    <= HTFS_RST_FRQ_HOLD;
			s_q.cfg.conversion_offset_enable <= HTFS_RST_OFFSET_EN;
			s_q.mask                         <= HTFS_RST_SAT_MASK;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_ack_o         = s_q.ack;
	assign wb_err_o         = s_q.err;
	assign wb_dat_o         = s_q.rdat;
	assign cfg_o            = s_q.cfg;
	assign freq_update_en_o = s_q.upd_en;
	assign irq_o            = irq_int;
endmodule

// ---- htfs_regs_assertions.sv ----
// Purpose: Port checker for the haptic trim/fault/snippet register slice
// Assumes: One clock, sync active-high reset, register index in adr[9:2]
// Notes:   Interrupt edges are tied to the saturation input or the bus writes that may cause them
`timescale 1ns/1ps
module htfs_assertions
	import htfs_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [HTFS_ADR_W-1:0] wb_adr_i,
	input  wire logic                 wb_ack_o,
	input  wire logic                 wb_err_o,
	input  wire logic                 adc_saturated_i,
	input  wire logic                 polarity_reversed_i,
	input  wire logic                 freq_update_req_i,
	input  wire logic                 freq_update_en_o,
	input  wire htfs_cfg_t            cfg_o,
	input  wire logic                 irq_o
);
	logic [7:0] ix;
	logic       wr;
	// Decoded write request, seen before the answer
	assign ix = wb_adr_i[9:2];
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// The edge right after an answer is not counted as a take
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !$past(wb_ack_o || wb_err_o);
	endsequence
	sequence s_answer;
		wb_ack_o || wb_err_o;
	endsequence
	a_take_answers: assert property (s_take |=> s_answer) else $error("request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
	a_freq_gate: assert property (!$past(rst_i) |-> freq_update_en_o ==
		$past(freq_update_req_i && !(cfg_o.freq_hold_on_reversal && polarity_reversed_i)))
		else $error("frequency update gate wrong");
	a_cfg_reset: assert property ($past(rst_i) |-> cfg_o == 7'h79) else $error("config reset value");
	a_cfg_quiet: assert property (!$past(rst_i) && !$stable(cfg_o) |-> $past(wr))
		else $error("config changed without a write");
	a_irq_rise: assert property ($rose(irq_o) && !$past(rst_i) |->
		$past(adc_saturated_i) || $past(wr && ix == HTFS_IDX_MASK)) else $error("irq rose without cause");
	a_irq_fall: assert property ($fell(irq_o) && !$past(rst_i) |->
		$past(wr && (ix == HTFS_IDX_EVENT || ix == HTFS_IDX_MASK))) else $error("irq fell without clear or mask");
endmodule
bind htfs_regs htfs_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .adc_saturated_i(adc_saturated_i), .polarity_reversed_i(polarity_reversed_i),
	.freq_update_req_i(freq_update_req_i), .freq_update_en_o(freq_update_en_o), .cfg_o(cfg_o),
	.irq_o(irq_o));

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the register slice
// Assumes: Wishbone classic, byte address = index * 4
// Notes:   Expectations come from the register map, not from the design
`timescale 1ns/1ps
module tb_top;
	import htfs_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, adc, rev, req, ack, err, irq, upd;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat;
	htfs_cfg_t   cfg;
	int          err_total, samples_checked;
	htfs_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .adc_saturated_i(adc), .polarity_reversed_i(rev), .freq_update_req_i(req),
		.freq_update_en_o(upd), .cfg_o(cfg), .irq_o(irq));
	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One classic cycle; held until ack or err is sampled, then released for a cycle
	task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] wd,
		output logic [7:0] rd, output logic e);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'h0};
		dat <= {24'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (!(ack || err) && n < 20);
		if (n >= 20) err_total++;
		rd = rdat[7:0];
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
		logic [7:0] d;
		logic       e;
		bus(1'b1, ix, wd, d, e);
	endtask
	task automatic rd(input logic [7:0] ix, input logic [7:0] exp, input logic ee);
		logic [7:0] d;
		logic       e;
		bus(1'b0, ix, 8'h0, d, e);
		chk({e, d & {8{!e}}}, {ee, exp});
	endtask
	// Hang guard
	initial begin
		repeat (3000) @(posedge clk_i);
		err_total++;
		summarize;
	end
	// Main sequence
	initial begin
		{rst_i, cyc, stb, we, adc, rev, req, adr, dat} = {1'b1, 48'h0};
		sel = 4'h1;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h62, 8'h0f, 1'b0);
		rd(8'h6e, 8'h01, 1'b0);
		rd(8'h81, 8'h00, 1'b0);
		rd(8'h82, 8'h00, 1'b0);
		rd(8'h83, 8'h00, 1'b0);
		rd(8'he7, 8'h00, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h62, 8'(c * 5));
			rd(8'h62, 8'(c * 5), 1'b0);
			chk({5'h0, cfg.low_side_slew_select, cfg.high_side_slew_select}, 9'(c * 5));
		end
		// A write without byte lane 0 is answered but stores nothing
		sel <= 4'h0;
		wr(8'h62, 8'h00);
		sel <= 4'h1;
		rd(8'h62, 8'h0f, 1'b0);
		wr(8'h6e, 8'h06);
		rd(8'h6e, 8'h06, 1'b0);
		chk({6'h0, cfg.delay_bypass, cfg.freq_hold_on_reversal, cfg.conversion_offset_enable}, 9'h6);
		// Updates paused only while hold is set and polarity reversed
		req <= 1'b1;
		rev <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({8'h0, upd}, 9'h0);
		rev <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({8'h0, upd}, 9'h1);
		wr(8'h6e, 8'h01);
		rev <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({8'h0, upd}, 9'h1);
		// One-cycle saturation pulse must stick
		adc <= 1'b1;
		@(posedge clk_i);
		adc <= 1'b0;
		@(posedge clk_i);
		chk({8'h0, irq}, 9'h1);
		rd(8'h81, 8'h04, 1'b0);
		wr(8'h82, 8'hff);
		rd(8'h82, 8'h80, 1'b0);
		wr(8'h83, 8'h80);
		chk({8'h0, irq}, 9'h0);
		wr(8'h83, 8'h00);
		chk({8'h0, irq}, 9'h1);
		wr(8'h81, 8'h04);
		chk({8'h0, irq}, 9'h0);
		rd(8'h81, 8'h00, 1'b0);
		rd(8'h82, 8'h00, 1'b0);
		for (int i = 0; i < 100; i++) wr(8'(8'h84 + i), 8'(i ^ 8'ha5));
		for (int i = 0; i < 100; i++) rd(8'(8'h84 + i), 8'(i ^ 8'ha5), 1'b0);
		rd(8'he8, 8'h00, 1'b1);
		rd(8'h63, 8'h00, 1'b1);
		summarize;
	end
endmodule
